// [dv/vci_regs_tb.sv]
// self-checking bench for the video input control and status bank
`default_nettype none
module vci_regs_tb import vci_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic w; logic [3:0] a; logic [15:0] d;} vci_row_s;
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic reg_read = 1'b0;
  logic reg_write = 1'b0;
  logic [15:0] reg_wdata = 16'h0000;
  logic [15:0] reg_rdata;
  logic [19:0] vid_data;
  logic vid_datavalid, vid_h_sync, vid_v_sync, vid_f;
  logic vid_locked = 1'b0;
  logic [2:0] vid_std = 3'h5;
  logic [19:0] dout_data;
  logic dout_sop, dout_valid, irq, overflow, frame_start, frame_start_locked, line_ref;
  logic dout_ready = 1'b0;
  logic intl = 1'b0;
  int bad_count = 0;
  int checks_done = 0;
  int c;
  // reads carry expected data, writes the data to write
  vci_row_s rows [15] = '{
    '{1'b0, 4'h0, 16'h0000},
    '{1'b0, 4'hb, 16'h0000},
    '{1'b0, 4'hc, 16'h0000},
    '{1'b0, 4'hd, 16'h0000},
    '{1'b0, 4'h3, 16'h0000},
    '{1'b1, 4'hb, 16'h1234},
    '{1'b0, 4'hb, 16'h1234},
    '{1'b1, 4'hc, 16'h00ff},
    '{1'b0, 4'hc, 16'h00ff},
    '{1'b1, 4'hd, 16'hffff},
    '{1'b0, 4'hd, 16'hffff},
    '{1'b1, 4'ha, 16'h1111},
    '{1'b0, 4'ha, 16'h0005},
    '{1'b0, 4'he, 16'h0000},
    '{1'b0, 4'hf, 16'h0000}
  };
  // ----------------------------------------------------------------
  // clock, design and video source
  // ----------------------------------------------------------------
  always #5 ref_clk = ~ref_clk;
  vci_regs dut_u (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .reg_addr(reg_addr),
    .reg_read(reg_read),
    .reg_write(reg_write),
    .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata),
    .vid_data(vid_data),
    .vid_datavalid(vid_datavalid),
    .vid_h_sync(vid_h_sync),
    .vid_v_sync(vid_v_sync),
    .vid_f(vid_f),
    .vid_locked(vid_locked),
    .vid_std(vid_std),
    .dout_data(dout_data),
    .dout_sop(dout_sop),
    .dout_valid(dout_valid),
    .dout_ready(dout_ready),
    .irq(irq),
    .overflow(overflow),
    .frame_start(frame_start),
    .frame_start_locked(frame_start_locked),
    .line_ref(line_ref)
  );
  vci_src src_u (
    .clk(ref_clk),
    .intl(intl),
    .h_sync(vid_h_sync),
    .v_sync(vid_v_sync),
    .f(vid_f),
    .datavalid(vid_datavalid),
    .data(vid_data)
  );
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic cmp(input string what, input logic [15:0] e, input logic [15:0] g);
    checks_done++;
    if (g !== e)
    begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, g);
    end
  endtask
  // word offsets only, one strobe cycle per access
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(negedge ref_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_write = 1'b1;
    @(negedge ref_clk);
    reg_write = 1'b0;
  endtask
  // read data arrives one edge after the read is taken
  task automatic rdc(input string what, input logic [3:0] a, input logic [15:0] m,
                     input logic [15:0] e);
    @(negedge ref_clk);
    reg_addr = a;
    reg_read = 1'b1;
    @(negedge ref_clk);
    reg_read = 1'b0;
    @(negedge ref_clk);
    cmp(what, e, reg_rdata & m);
  endtask
  task automatic pulses(input logic fs, input int n);
    c = 0;
    repeat (n)
    begin
      @(negedge ref_clk);
      c += fs ? int'(frame_start) : int'(line_ref);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // watchdog sized well above the roughly seven thousand cycles of the tests
  initial
  begin
    repeat (40000) @(posedge ref_clk);
    bad_count++;
    complete_run;
  end
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (20) @(posedge ref_clk);
    @(negedge ref_clk);
    arst_n = 1'b1;
    repeat (3) @(negedge ref_clk);
    cmp("irq", 16'h0000, {15'h0000, irq});
    cmp("dout_valid", 16'h0000, {15'h0000, dout_valid});
    foreach (rows[i])
    begin
      if (rows[i].w)
        wr(rows[i].a, rows[i].d);
      else
        rdc("register", rows[i].a, 16'hffff, rows[i].d);
    end
    $display("test registers done");
    wr(OFS_CTRL, 16'h0004);
    rdc("control", OFS_CTRL, 16'h000f, 16'h0004);
    vid_locked = 1'b1;
    repeat (3) @(posedge vid_v_sync);
    rdc("active samples", OFS_ACT_SMP, 16'hffff, 16'h0020);
    rdc("even active lines", OFS_F0_ACT, 16'hffff, 16'h000a);
    rdc("total samples", OFS_TOT_SMP, 16'hffff, 16'h0028);
    rdc("even total lines", OFS_F0_TOT, 16'hffff, 16'h000c);
    wr(OFS_TOT_SMP, 16'h0000);
    rdc("total samples kept", OFS_TOT_SMP, 16'hffff, 16'h0028);
    rdc("status", OFS_STAT, 16'h07bf, 16'h0538);
    rdc("pending", OFS_IRQ, 16'h0006, 16'h0006);
    cmp("irq stable", 16'h0001, {15'h0000, irq});
    wr(OFS_IRQ, 16'h0004);
    rdc("pending", OFS_IRQ, 16'h0006, 16'h0002);
    cmp("irq gated", 16'h0000, {15'h0000, irq});
    wr(OFS_CTRL, 16'h0002);
    cmp("irq change", 16'h0001, {15'h0000, irq});
    wr(OFS_IRQ, 16'h0002);
    rdc("pending", OFS_IRQ, 16'h0006, 16'h0000);
    cmp("irq cleared", 16'h0000, {15'h0000, irq});
    $display("test measure done");
    wr(OFS_SOF_SMP, 16'h0015);
    wr(OFS_SOF_LN, 16'h0003);
    wr(OFS_DIV, 16'h0005);
    wr(OFS_CTRL, 16'h0000);
    pulses(1'b0, 100);
    cmp("line ref off", 16'h0000, 16'(c));
    pulses(1'b1, 480);
    cmp("frame start off", 16'h0000, 16'(c));
    cmp("lock off", 16'h0000, {15'h0000, frame_start_locked});
    wr(OFS_CTRL, 16'h0008);
    pulses(1'b0, 100);
    cmp("line ref", 16'h0014, 16'(c));
    pulses(1'b1, 480);
    cmp("frame start", 16'h0001, 16'(c));
    cmp("lock on", 16'h0001, {15'h0000, frame_start_locked});
    $display("test sync done");
    @(posedge vid_v_sync);
    repeat (10) @(negedge ref_clk);
    wr(OFS_CTRL, 16'h0001);
    rdc("not yet running", OFS_STAT, 16'h0001, 16'h0000);
    @(posedge vid_v_sync);
    rdc("running", OFS_STAT, 16'h0001, 16'h0001);
    repeat (150) @(negedge ref_clk);
    rdc("fill", OFS_FILL, 16'hffff, 16'h0010);
    rdc("overflow bit", OFS_STAT, 16'h0200, 16'h0200);
    cmp("overflow out", 16'h0001, {15'h0000, overflow});
    wr(OFS_CTRL, 16'h0000);
    repeat (2) @(posedge vid_v_sync);
    rdc("stopped", OFS_STAT, 16'h0001, 16'h0000);
    @(negedge ref_clk);
    dout_ready = 1'b1;
    c = 0;
    while (dout_valid === 1'b1 && c < 40)
    begin
      cmp("stream data", 16'(8 + c), 16'(dout_data));
      if (c == 0)
        cmp("start flag", 16'h0001, {15'h0000, dout_sop});
      c++;
      @(negedge ref_clk);
    end
    cmp("popped", 16'h0010, 16'(c));
    rdc("fill empty", OFS_FILL, 16'hffff, 16'h0000);
    rdc("overflow held", OFS_STAT, 16'h0200, 16'h0200);
    wr(OFS_STAT, 16'h0200);
    rdc("overflow cleared", OFS_STAT, 16'h0200, 16'h0000);
    cmp("overflow out low", 16'h0000, {15'h0000, overflow});
    $display("test stream done");
    intl = 1'b1;
    repeat (6) @(posedge vid_v_sync);
    rdc("interlaced", OFS_STAT, 16'h00c0, 16'h00c0);
    rdc("odd active lines", OFS_F1_ACT, 16'hffff, 16'h000a);
    rdc("odd total lines", OFS_F1_TOT, 16'hffff, 16'h000c);
    $display("test interlace done");
    complete_run;
  end
endmodule
`default_nettype wire

// [dv/vci_src.sv]
// behavioural video source with separate syncs, driven on the falling edge
`default_nettype none
module vci_src #(
  parameter int HT = 40,
  parameter int HB = 8,
  parameter int VT = 12,
  parameter int VB = 2,
  parameter int DW = 20
) (
  input wire logic clk,
  input wire logic intl,
  output logic h_sync,
  output logic v_sync,
  output logic f,
  output logic datavalid,
  output logic [DW-1:0] data
);
  timeunit 1ns;
  timeprecision 1ps;
  int h = 0;
  int ln = 0;
  // ----------------------------------------------------------------
  // raster counters and sync outputs
  // ----------------------------------------------------------------
  initial
  begin
    h_sync = 1'b0;
    v_sync = 1'b0;
    f = 1'b0;
    datavalid = 1'b0;
    data = '0;
  end
  // field id alternates only while interlaced input is asked for
  always @(negedge clk)
  begin
    h = (h == HT - 1) ? 0 : h + 1;
    if (h == 0)
    begin
      ln = (ln == VT - 1) ? 0 : ln + 1;
      if (ln == 0)
        f <= intl & ~f;
    end
    h_sync <= (h < 4);
    v_sync <= (ln == 0);
    datavalid <= (h >= HB) && (ln >= VB);
    // blanked samples carry the inverted count, so stale data never looks valid
    data <= (h >= HB && ln >= VB) ? DW'(h) : ~DW'(h);
  end
endmodule
`default_nettype wire

// [logic/vci_pkg.sv]
// constants shared by the video input control and status bank
`default_nettype none
package vci_pkg;
  localparam int REG_W = 16;
  localparam int ADDR_W = 4;
  localparam int FIFO_DEPTH = 16;
  // register word offsets
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_STAT = 4'h1;
  localparam logic [3:0] OFS_IRQ = 4'h2;
  localparam logic [3:0] OFS_FILL = 4'h3;
  localparam logic [3:0] OFS_ACT_SMP = 4'h4;
  localparam logic [3:0] OFS_F0_ACT = 4'h5;
  localparam logic [3:0] OFS_F1_ACT = 4'h6;
  localparam logic [3:0] OFS_TOT_SMP = 4'h7;
  localparam logic [3:0] OFS_F0_TOT = 4'h8;
  localparam logic [3:0] OFS_F1_TOT = 4'h9;
  localparam logic [3:0] OFS_STD = 4'ha;
  localparam logic [3:0] OFS_SOF_SMP = 4'hb;
  localparam logic [3:0] OFS_SOF_LN = 4'hc;
  localparam logic [3:0] OFS_DIV = 4'hd;
  // control bits
  localparam int CTL_GO = 0;
  localparam int CTL_IE_CHG = 1;
  localparam int CTL_IE_STB = 2;
  localparam int CTL_SYNC_EN = 3;
  // status bits
  localparam int ST_RUN = 0;
  localparam int ST_INTL = 7;
  localparam int ST_STABLE = 8;
  localparam int ST_OVF = 9;
  localparam int ST_RES = 10;
  // pending interrupt bits
  localparam int IRQ_CHG = 1;
  localparam int IRQ_STB = 2;
  // reset values
  localparam logic [15:0] CTRL_RST = 16'h0000;
  localparam logic [15:0] SOF_SMP_RST = 16'h0000;
  localparam logic [15:0] SOF_LN_RST = 16'h0000;
  localparam logic [15:0] DIV_RST = 16'h0000;
  typedef enum logic {VCI_IDLE = 1'b0, VCI_RUN = 1'b1} vci_run_e;
endpackage
`default_nettype wire

// [logic/vci_regs.sv]
// video input control and status register bank with its sample fifo
// ----------------------------------------------------------------
// ----------------------------------------------------------------
`default_nettype none

// simple synchronous fifo, valid and ready on both sides
module vci_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16,
  parameter int CW = $clog2(DEPTH) + 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [CW-1:0] count
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic [CW-1:0] cnt_r, cnt_nxt;
  logic push, pop;

  // pointer and level update
  always_comb
  begin
    in_ready = (cnt_r != CW'(DEPTH));
    out_valid = (cnt_r != '0);
    out_data = mem[rp_r];
    push = in_valid & in_ready;
    pop = out_valid & out_ready;
    wp_nxt = push ? PW'(wp_r + 1'b1) : wp_r;
    rp_nxt = pop ? PW'(rp_r + 1'b1) : rp_r;
    cnt_nxt = CW'(cnt_r + CW'(push) - CW'(pop));
    count = cnt_r;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end
    else
    begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // storage, written only on an accepted push
  always_ff @(posedge clk)
  begin
    if (push)
      mem[wp_r] <= in_data;
  end
endmodule

module vci_regs
  import vci_pkg::*;
#(
  parameter int DATA_W = 20,
  parameter int STD_W = 3
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic reg_read,
  input wire logic reg_write,
  input wire logic [REG_W-1:0] reg_wdata,
  output logic [REG_W-1:0] reg_rdata,
  input wire logic [DATA_W-1:0] vid_data,
  input wire logic vid_datavalid,
  input wire logic vid_h_sync,
  input wire logic vid_v_sync,
  input wire logic vid_f,
  input wire logic vid_locked,
  input wire logic [STD_W-1:0] vid_std,
  output logic [DATA_W-1:0] dout_data,
  output logic dout_sop,
  output logic dout_valid,
  input wire logic dout_ready,
  output logic irq,
  output logic overflow,
  output logic frame_start,
  output logic frame_start_locked,
  output logic line_ref
);
  localparam int CW = $clog2(FIFO_DEPTH) + 1;
  logic rst_meta_r, rst_n;
  logic [15:0] ctrl_r, ctrl_nxt, sof_smp_r, sof_smp_nxt, sof_ln_r, sof_ln_nxt;
  logic [15:0] div_r, div_nxt, rdata_r, rdata_nxt;
  logic hs_d_r, vs_d_r, hs_rise, vs_rise, frame_edge;
  logic [15:0] h_cnt_r, h_cnt_nxt, act_cnt_r, act_cnt_nxt, line_len;
  logic [15:0] v_cnt_r, v_cnt_nxt, vact_r, vact_nxt, len1_r, len1_nxt, len2_r, len2_nxt;
  logic [15:0] act_smp_r, act_smp_nxt, tot_smp_r, tot_smp_nxt;
  logic [15:0] f0_act_r, f0_act_nxt, f0_tot_r, f0_tot_nxt;
  logic [15:0] f1_act_r, f1_act_nxt, f1_tot_r, f1_tot_nxt;
  logic line_act_r, line_act_nxt, stable_r, stable_nxt, fld_r, fld_nxt;
  logic seen_odd_r, seen_odd_nxt, intl_r, intl_nxt;
  logic [3:0] vld_r, vld_nxt;
  vci_run_e run_r, run_nxt;
  logic first_r, first_nxt, ovf_r, ovf_nxt, ovf_out_r;
  logic [2:1] pend_r, pend_nxt;
  logic [15:0] stat_w;
  logic [7:0] stat_prev_r;
  logic wr_stat, wr_irq, res_ok, push_v, in_ready, ovf_set;
  logic [CW-1:0] fill;
  logic sync_en, sof_hit, sof_r, sof_nxt, lref_r, lref_nxt;
  logic [2:0] sof_dly_r, sof_dly_nxt;
  logic [15:0] div_cnt_r, div_cnt_nxt;

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  // two stage release keeps the deassertion synchronous to ref_clk
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rst_meta_r <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_meta_r <= 1'b1;
      rst_n <= rst_meta_r;
    end
  end

  // ----------------------------------------------------------------
  // register port
  // ----------------------------------------------------------------
  // status word composed from live state; unused bits read zero
  assign res_ok = vld_r[0] & vld_r[1] & (vld_r[3] | ~intl_r);
  assign stat_w = {5'h00, res_ok, ovf_r, stable_r, intl_r, vld_r, 2'h0, run_r};
  assign wr_stat = reg_write && (reg_addr == OFS_STAT);
  assign wr_irq = reg_write && (reg_addr == OFS_IRQ);

  // writable registers and registered read data; word offsets only
  always_comb
  begin
    ctrl_nxt = ctrl_r;
    sof_smp_nxt = sof_smp_r;
    sof_ln_nxt = sof_ln_r;
    div_nxt = div_r;
    rdata_nxt = rdata_r;
    if (reg_write)
    begin
      case (reg_addr)
        OFS_CTRL: ctrl_nxt = reg_wdata;
        OFS_SOF_SMP: sof_smp_nxt = reg_wdata;
        OFS_SOF_LN: sof_ln_nxt = reg_wdata;
        OFS_DIV: div_nxt = reg_wdata;
        default: ctrl_nxt = ctrl_r;
      endcase
    end
    if (reg_read)
    begin
      case (reg_addr)
        OFS_CTRL: rdata_nxt = ctrl_r;
        OFS_STAT: rdata_nxt = stat_w;
        OFS_IRQ: rdata_nxt = {13'h0000, pend_r, 1'b0};
        OFS_FILL: rdata_nxt = 16'(fill);
        OFS_ACT_SMP: rdata_nxt = act_smp_r;
        OFS_F0_ACT: rdata_nxt = f0_act_r;
        OFS_F1_ACT: rdata_nxt = f1_act_r;
        OFS_TOT_SMP: rdata_nxt = tot_smp_r;
        OFS_F0_TOT: rdata_nxt = f0_tot_r;
        OFS_F1_TOT: rdata_nxt = f1_tot_r;
        OFS_STD: rdata_nxt = 16'(vid_std);
        OFS_SOF_SMP: rdata_nxt = sof_smp_r;
        OFS_SOF_LN: rdata_nxt = sof_ln_r;
        OFS_DIV: rdata_nxt = div_r;
        default: rdata_nxt = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl_r <= CTRL_RST;
      sof_smp_r <= SOF_SMP_RST;
      sof_ln_r <= SOF_LN_RST;
      div_r <= DIV_RST;
      rdata_r <= 16'h0000;
    end
    else
    begin
      ctrl_r <= ctrl_nxt;
      sof_smp_r <= sof_smp_nxt;
      sof_ln_r <= sof_ln_nxt;
      div_r <= div_nxt;
      rdata_r <= rdata_nxt;
    end
  end
  assign reg_rdata = rdata_r;

  // ----------------------------------------------------------------
  // input measurement
  // ----------------------------------------------------------------
  assign hs_rise = vid_h_sync & ~hs_d_r;
  assign vs_rise = vid_v_sync & ~vs_d_r;
  assign frame_edge = vs_rise & ~vid_f;
  assign line_len = 16'(h_cnt_r + 16'h0001);

  // line and field counters; field end stores into the ending field,
  // counting the line that the coincident hsync edge closes as well
  always_comb
  begin
    h_cnt_nxt = hs_rise ? 16'h0000 : 16'(h_cnt_r + 16'h0001);
    act_cnt_nxt = hs_rise ? 16'h0000 : 16'(act_cnt_r + {15'h0000, vid_datavalid});
    line_act_nxt = hs_rise ? 1'b0 : (line_act_r | vid_datavalid);
    {v_cnt_nxt, vact_nxt, len1_nxt, len2_nxt} = {v_cnt_r, vact_r, len1_r, len2_r};
    {act_smp_nxt, tot_smp_nxt, stable_nxt, vld_nxt} = {act_smp_r, tot_smp_r, stable_r, vld_r};
    {f0_act_nxt, f0_tot_nxt, f1_act_nxt, f1_tot_nxt} = {f0_act_r, f0_tot_r, f1_act_r, f1_tot_r};
    {fld_nxt, intl_nxt} = {fld_r, intl_r};
    seen_odd_nxt = seen_odd_r | vid_f;
    if (hs_rise)
    begin
      tot_smp_nxt = line_len;
      if (line_act_r) // blank lines keep the last active width
        act_smp_nxt = act_cnt_r;
      len1_nxt = line_len;
      len2_nxt = len1_r;
      stable_nxt = (line_len == len1_r) || (line_len == len2_r) || (len1_r == len2_r);
      v_cnt_nxt = 16'(v_cnt_r + 16'h0001);
      vact_nxt = 16'(vact_r + {15'h0000, line_act_r});
      vld_nxt[0] = 1'b1;
      vld_nxt[2] = 1'b1;
    end
    if (vs_rise)
    begin
      if (fld_r)
      begin
        f1_tot_nxt = v_cnt_nxt;
        f1_act_nxt = vact_nxt;
        vld_nxt[3] = 1'b1;
      end
      else
      begin
        f0_tot_nxt = v_cnt_nxt;
        f0_act_nxt = vact_nxt;
        vld_nxt[1] = 1'b1;
      end
      v_cnt_nxt = 16'h0000;
      vact_nxt = 16'h0000;
      fld_nxt = vid_f;
      if (!vid_f)
      begin
        intl_nxt = seen_odd_r;
        seen_odd_nxt = 1'b0;
      end
    end
    if (!vid_locked)
    begin
      vld_nxt = 4'h0;
      stable_nxt = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      {hs_d_r, vs_d_r, h_cnt_r, act_cnt_r, line_act_r} <= '0;
      {v_cnt_r, vact_r, len1_r, len2_r, act_smp_r, tot_smp_r} <= '0;
      {f0_act_r, f0_tot_r, f1_act_r, f1_tot_r, stable_r, vld_r} <= '0;
      {fld_r, intl_r, seen_odd_r} <= '0;
    end
    else
    begin
      {hs_d_r, vs_d_r} <= {vid_h_sync, vid_v_sync};
      {h_cnt_r, act_cnt_r, line_act_r} <= {h_cnt_nxt, act_cnt_nxt, line_act_nxt};
      {v_cnt_r, vact_r, len1_r, len2_r} <= {v_cnt_nxt, vact_nxt, len1_nxt, len2_nxt};
      {act_smp_r, tot_smp_r, stable_r, vld_r} <= {act_smp_nxt, tot_smp_nxt, stable_nxt, vld_nxt};
      {f0_act_r, f0_tot_r, f1_act_r, f1_tot_r} <= {f0_act_nxt, f0_tot_nxt, f1_act_nxt, f1_tot_nxt};
      {fld_r, intl_r, seen_odd_r} <= {fld_nxt, intl_nxt, seen_odd_nxt};
    end
  end

  // ----------------------------------------------------------------
  // run control, stream path, sticky flags
  // ----------------------------------------------------------------
  assign push_v = (run_r == VCI_RUN) & vid_datavalid;
  assign ovf_set = push_v & ~in_ready;

  vci_fifo #(.WIDTH(DATA_W + 1), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(ref_clk),
    .rst_n(rst_n),
    .in_data({first_r, vid_data}),
    .in_valid(push_v),
    .in_ready(in_ready),
    .out_data({dout_sop, dout_data}),
    .out_valid(dout_valid),
    .out_ready(dout_ready),
    .count(fill)
  );

  // run changes only on an even field start; sets win over clears
  always_comb
  begin
    run_nxt = run_r;
    first_nxt = first_r & ~(push_v & in_ready);
    if (frame_edge)
    begin
      run_nxt = ctrl_r[CTL_GO] ? VCI_RUN : VCI_IDLE;
      first_nxt = ctrl_r[CTL_GO];
    end
    ovf_nxt = ovf_set | (ovf_r & ~(wr_stat & reg_wdata[ST_OVF]));
    pend_nxt = pend_r & ~(wr_irq ? reg_wdata[2:1] : 2'h0);
    if (stat_w[10:3] != stat_prev_r)
      pend_nxt[IRQ_CHG] = 1'b1;
    if (stable_nxt & ~stable_r)
      pend_nxt[IRQ_STB] = 1'b1;
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      run_r <= VCI_IDLE;
      {first_r, ovf_r, ovf_out_r, pend_r, stat_prev_r} <= '0;
    end
    else
    begin
      run_r <= run_nxt;
      {first_r, ovf_r, pend_r} <= {first_nxt, ovf_nxt, pend_nxt};
      ovf_out_r <= ovf_r;
      stat_prev_r <= stat_w[10:3];
    end
  end
  // interrupt follows pending flags through their enables
  assign irq = (pend_r[IRQ_CHG] & ctrl_r[CTL_IE_CHG]) | (pend_r[IRQ_STB] & ctrl_r[CTL_IE_STB]);
  assign overflow = ovf_out_r;

  // ----------------------------------------------------------------
  // synchronization outputs
  // ----------------------------------------------------------------
  assign sync_en = ctrl_r[CTL_SYNC_EN];
  assign sof_hit = sync_en && !fld_r && (v_cnt_r == sof_ln_r) &&
                   (h_cnt_r == {2'h0, sof_smp_r[15:2]});

  // frame start delayed by the subsample count; divider for line reference
  always_comb
  begin
    sof_dly_nxt = (sof_dly_r != 3'h0) ? 3'(sof_dly_r - 3'h1) : 3'h0;
    if (sof_hit)
      sof_dly_nxt = 3'({1'b0, sof_smp_r[1:0]} + 3'h1);
    sof_nxt = sync_en && (sof_dly_r == 3'h1);
    div_cnt_nxt = 16'(div_cnt_r + 16'h0001);
    lref_nxt = 1'b0;
    if (!sync_en || div_r == 16'h0000)
      div_cnt_nxt = 16'h0000;
    else if (div_cnt_r == 16'(div_r - 16'h0001))
    begin
      div_cnt_nxt = 16'h0000;
      lref_nxt = 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      {sof_dly_r, sof_r, div_cnt_r, lref_r} <= '0;
    else
      {sof_dly_r, sof_r, div_cnt_r, lref_r} <= {sof_dly_nxt, sof_nxt, div_cnt_nxt, lref_nxt};
  end
  assign frame_start = sof_r;
  assign line_ref = lref_r;
  assign frame_start_locked = sync_en & vid_locked & stable_r;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  a_go_waits: assert property ((run_r == VCI_IDLE) && !frame_edge |=> run_r == VCI_IDLE)
    else $error("stream started off a frame boundary");
  a_stat_run: assert property (reg_read && reg_addr == OFS_STAT |=> reg_rdata[0] == $past(run_r))
    else $error("status run bit wrong");
  a_ovf_hold: assert property (ovf_r && !(wr_stat && reg_wdata[ST_OVF]) |=> ovf_r)
    else $error("overflow flag dropped without clear");
  a_ovf_mirror: assert property (ovf_set |=> ##1 overflow)
    else $error("overflow output did not follow");
  a_pend_hold: assert property (pend_r[IRQ_STB] && !(wr_irq && reg_wdata[IRQ_STB]) |=> pend_r[IRQ_STB])
    else $error("pending flag dropped");
  a_irq_gate: assert property (irq |-> (pend_r[1] && ctrl_r[1]) || (pend_r[2] && ctrl_r[2]))
    else $error("interrupt without enabled cause");
  a_sync_off: assert property (!sync_en [*2] |-> !line_ref && !frame_start)
    else $error("sync outputs active while disabled");
  a_fill_read: assert property (reg_read && reg_addr == OFS_FILL |=> reg_rdata == 16'($past(fill)))
    else $error("fill level readback wrong");
  a_div_gap: assert property (line_ref && div_r > 16'h0001 && sync_en |=> !line_ref)
    else $error("line reference pulses too close");
  a_meas_ro: assert property (reg_write && !hs_rise |=> tot_smp_r == $past(tot_smp_r))
    else $error("measurement changed by a write");

  c_run_start: cover property ((run_r == VCI_IDLE) ##1 (run_r == VCI_RUN));
  c_overflow: cover property (ovf_set);
  c_frame_start: cover property (frame_start);
  c_line_ref: cover property (line_ref ##[1:20] line_ref);
endmodule
`default_nettype wire
